// ---- tfit_pkg.sv ----
// Purpose: Shared constants for the trace funnel integration test register bank
// Assumes: 12-bit APB byte addresses, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package tfit_pkg;
    localparam logic [11:0] TFIT_OFS_FUNNEL_CTRL = 12'h000;
    localparam logic [11:0] TFIT_OFS_DATA_TEST   = 12'heec;
    localparam logic [11:0] TFIT_OFS_SYNC_TEST   = 12'hef0;
    localparam logic [11:0] TFIT_OFS_FLUSH_TEST  = 12'hef4;
    localparam logic [11:0] TFIT_OFS_ID_TEST     = 12'hef8;
    localparam logic [11:0] TFIT_OFS_VBYTES_TEST = 12'hefc;
    localparam logic [11:0] TFIT_OFS_ITMODE      = 12'hf00;

    localparam int          TFIT_FC_W        = 13;
    localparam logic [12:0] TFIT_FC_RESET    = 13'h0300;
    localparam int          TFIT_DT_W        = 17;
    localparam int          TFIT_DT_TOP_BIT  = 16;
    localparam int          TFIT_DATA_W      = 128;
    localparam int          TFIT_ID_W        = 7;
    localparam int          TFIT_BYTES_W     = 2;
    localparam int          TFIT_BYTES_LSB   = 8;
    localparam int          TFIT_NPORTS      = 8;
endpackage

// ---- tfit_port_view.sv ----
// Purpose: Merge the slave-side signals of the enabled funnel ports into one view
// Assumes: Software enables exactly one port during integration test
// Notes:   More than one enable gives the OR of the ports, none gives zero
`timescale 1ns/1ps
module tfit_port_view
    import tfit_pkg::*;
#(
    parameter int NPORTS = TFIT_NPORTS,
    parameter int WIDTH  = 1
) (
    // Selection
    input  wire logic [NPORTS-1:0]       i_enable,
    // Per-port signals
    input  wire logic [NPORTS*WIDTH-1:0] i_ports,
    // Merged view
    output logic      [WIDTH-1:0]        o_view
);
    always_comb begin
        o_view = '0;
        for (int p = 0; p < NPORTS; p++) begin
            if (i_enable[p]) begin
                o_view = o_view | i_ports[p*WIDTH +: WIDTH];
            end
        end
    end
endmodule

// ---- tfit_regs.sv ----
// Purpose: Integration test register bank of a multi-input trace funnel
// Assumes: APB4 slave, single clock, synchronous active-high reset
// Notes:   Functional funnel outputs arrive on i_fn_* and pass through outside test mode
`timescale 1ns/1ps
//
// Overview of operation
// - Data test bits 15..0 map to trace bits 119,111,...,7,0.
// - Data test read gives slave line level; write sets master line level.
// - Latch catches master sync-request pulses; sync test bit 0 reads it.
// - Reading the sync test register clears the latch.
// - Writing 1 to sync bit 0 sends one slave-side sync pulse.
// - Flush test bit 1 reads master flush-valid, writes slave flush-valid.
// - Flush test bit 0 reads master ready, writes slave ready.
// - ID test bits 6..0 read slave ID, write master ID.
// - Valid-bytes bits 9..8 read slave byte count, write master byte count.
// - Valid-bytes bit 1 reads slave flush-ready, writes master flush-ready.
// - Valid-bytes bit 0 reads slave valid, writes master valid.
// - Slave-side reads observe the ports enabled in funnel control.
// - Integration mode bit 0 enables test mode; other bits read zero.
// - Data test bit 16 reads slave bit 127, writes master bit 127.
// - Funnel control low eight bits enable individual slave ports.
module tfit_regs
    import tfit_pkg::*;
#(
    parameter int NPORTS = TFIT_NPORTS
) (
    // Clock and reset
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_rst,
    // APB4 slave
    input  wire logic                            i_psel,
    input  wire logic                            i_penable,
    input  wire logic                            i_pwrite,
    input  wire logic [11:0]                     i_paddr,
    input  wire logic [31:0]                     i_pwdata,
    input  wire logic [3:0]                      i_pstrb,
    output logic      [31:0]                     o_prdata,
    output logic                                 o_pready,
    output logic                                 o_pslverr,
    // Slave-side inputs from trace sources
    input  wire logic [NPORTS*TFIT_DATA_W-1:0]   i_atdata_s,
    input  wire logic [NPORTS*TFIT_ID_W-1:0]     i_atid_s,
    input  wire logic [NPORTS*TFIT_BYTES_W-1:0]  i_atbytes_s,
    input  wire logic [NPORTS-1:0]               i_atvalid_s,
    input  wire logic [NPORTS-1:0]               i_afready_s,
    // Slave-side outputs to trace sources
    output logic      [NPORTS-1:0]               o_atready_s,
    output logic      [NPORTS-1:0]               o_afvalid_s,
    output logic      [NPORTS-1:0]               o_syncreq_s,
    // Master-side inputs from trace sink
    input  wire logic                            i_atready_m,
    input  wire logic                            i_afvalid_m,
    input  wire logic                            i_syncreq_m,
    // Master-side outputs to trace sink
    output logic      [TFIT_DATA_W-1:0]          o_atdata_m,
    output logic      [TFIT_ID_W-1:0]            o_atid_m,
    output logic      [TFIT_BYTES_W-1:0]         o_atbytes_m,
    output logic                                 o_atvalid_m,
    output logic                                 o_afready_m,
    // Functional funnel outputs used outside integration mode
    input  wire logic [NPORTS-1:0]               i_fn_atready_s,
    input  wire logic [NPORTS-1:0]               i_fn_afvalid_s,
    input  wire logic [NPORTS-1:0]               i_fn_syncreq_s,
    input  wire logic [TFIT_DATA_W-1:0]          i_fn_atdata_m,
    input  wire logic [TFIT_ID_W-1:0]            i_fn_atid_m,
    input  wire logic [TFIT_BYTES_W-1:0]         i_fn_atbytes_m,
    input  wire logic                            i_fn_atvalid_m,
    input  wire logic                            i_fn_afready_m,
    // Control state for the funnel datapath
    output logic      [TFIT_FC_W-1:0]            o_funnel_ctrl,
    output logic                                 o_itmode
);
    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Trace bus bit carried by each data test bit
    function automatic int data_bit(input int k);
        int pos;
        pos = (k == 0) ? 0 : 8 * k - 1;
        if (k == TFIT_DT_TOP_BIT) begin
            pos = TFIT_DATA_W - 1;
        end
        return pos;
    endfunction

    logic [TFIT_FC_W-1:0]    fc_r;
    logic                    itmode_r;
    logic [TFIT_DT_W-1:0]    dt_r;
    logic [1:0]              fh_r;
    logic [TFIT_ID_W-1:0]    id_r;
    logic [TFIT_BYTES_W-1:0] vb_bytes_r;
    logic [1:0]              vb_ctl_r;
    logic                    sync_latch_r;
    logic                    sync_pulse_r;

    // APB decode: everything acts in the setup cycle, answer comes next cycle
    wire logic setup    = i_psel & ~i_penable;
    wire logic wr       = setup & i_pwrite;
    wire logic rd       = setup & ~i_pwrite;
    wire logic hit_fc   = (i_paddr == TFIT_OFS_FUNNEL_CTRL);
    wire logic hit_dt   = (i_paddr == TFIT_OFS_DATA_TEST);
    wire logic hit_sync = (i_paddr == TFIT_OFS_SYNC_TEST);
    wire logic hit_fh   = (i_paddr == TFIT_OFS_FLUSH_TEST);
    wire logic hit_id   = (i_paddr == TFIT_OFS_ID_TEST);
    wire logic hit_vb   = (i_paddr == TFIT_OFS_VBYTES_TEST);
    wire logic hit_it   = (i_paddr == TFIT_OFS_ITMODE);
    wire logic [31:0] wmerge_dt = merge_strb({15'h0000, dt_r}, i_pwdata, i_pstrb);
    wire logic [31:0] wmerge_fc = merge_strb({19'h00000, fc_r}, i_pwdata, i_pstrb);
    wire logic [NPORTS-1:0] port_en = fc_r[NPORTS-1:0];

    // Observed slave-side view of the enabled ports
    logic [TFIT_DATA_W-1:0]  sv_data;
    logic [TFIT_ID_W-1:0]    sv_id;
    logic [TFIT_BYTES_W-1:0] sv_bytes;
    // A net, since its two bits come from two separate view instances
    wire logic [1:0]         sv_ctl;

    tfit_port_view #(.NPORTS(NPORTS), .WIDTH(TFIT_DATA_W)) u_view_data (
        .i_enable (port_en),
        .i_ports  (i_atdata_s),
        .o_view   (sv_data)
    );
    tfit_port_view #(.NPORTS(NPORTS), .WIDTH(TFIT_ID_W)) u_view_id (
        .i_enable (port_en),
        .i_ports  (i_atid_s),
        .o_view   (sv_id)
    );
    tfit_port_view #(.NPORTS(NPORTS), .WIDTH(TFIT_BYTES_W)) u_view_bytes (
        .i_enable (port_en),
        .i_ports  (i_atbytes_s),
        .o_view   (sv_bytes)
    );
    tfit_port_view #(.NPORTS(NPORTS), .WIDTH(1)) u_view_valid (
        .i_enable (port_en),
        .i_ports  (i_atvalid_s),
        .o_view   (sv_ctl[0])
    );
    tfit_port_view #(.NPORTS(NPORTS), .WIDTH(1)) u_view_afready (
        .i_enable (port_en),
        .i_ports  (i_afready_s),
        .o_view   (sv_ctl[1])
    );

    // Data test gather and scatter
    logic [TFIT_DT_W-1:0]   dt_read;
    logic [TFIT_DATA_W-1:0] dt_drive;
    always_comb begin
        dt_drive = '0;
        for (int k = 0; k < TFIT_DT_W; k++) begin
            dt_read[k]           = sv_data[data_bit(k)];
            dt_drive[data_bit(k)] = dt_r[k];
        end
    end

    // Read mux; unmapped words read as zero
    wire logic [31:0] rdata =
        hit_fc   ? {19'h00000, fc_r} :
        hit_dt   ? {15'h0000, dt_read} :
        hit_sync ? {31'h00000000, sync_latch_r} :
        hit_fh   ? {30'h00000000, i_afvalid_m, i_atready_m} :
        hit_id   ? {25'h0000000, sv_id} :
        hit_vb   ? {22'h000000, sv_bytes, 6'h00, sv_ctl} :
        hit_it   ? {31'h00000000, itmode_r} :
        32'h00000000;

    // A pulse arriving during the clearing read is kept
    wire logic sync_latch_nxt = i_syncreq_m | (sync_latch_r & ~(rd & hit_sync));
    wire logic sync_pulse_nxt = wr & hit_sync & i_pstrb[0] & i_pwdata[0];

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_prdata  <= 32'h00000000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_prdata  <= rd ? rdata : 32'h00000000;
            o_pready  <= setup;
            o_pslverr <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            fc_r         <= TFIT_FC_RESET;
            itmode_r     <= 1'b0;
            dt_r         <= '0;
            fh_r         <= 2'h0;
            id_r         <= '0;
            vb_bytes_r   <= '0;
            vb_ctl_r     <= 2'h0;
            sync_latch_r <= 1'b0;
            sync_pulse_r <= 1'b0;
        end else begin
            sync_latch_r <= sync_latch_nxt;
            sync_pulse_r <= sync_pulse_nxt;
            if (wr && hit_fc) begin
                fc_r <= wmerge_fc[TFIT_FC_W-1:0];
            end
            if (wr && hit_it && i_pstrb[0]) begin
                itmode_r <= i_pwdata[0];
            end
            if (wr && hit_dt) begin
                dt_r <= wmerge_dt[TFIT_DT_W-1:0];
            end
            if (wr && hit_fh && i_pstrb[0]) begin
                fh_r <= i_pwdata[1:0];
            end
            if (wr && hit_id && i_pstrb[0]) begin
                id_r <= i_pwdata[TFIT_ID_W-1:0];
            end
            if (wr && hit_vb && i_pstrb[1]) begin
                vb_bytes_r <= i_pwdata[TFIT_BYTES_LSB +: TFIT_BYTES_W];
            end
            if (wr && hit_vb && i_pstrb[0]) begin
                vb_ctl_r <= i_pwdata[1:0];
            end
        end
    end

    // Output stage: test values in integration mode, aimed at enabled ports; the sync test pulse reaches them in both modes.
    // Registering the mux costs one cycle of latency on the functional path.
    wire logic [NPORTS-1:0] sync_vec = {NPORTS{sync_pulse_r}} & port_en;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_atready_s <= '0;
            o_afvalid_s <= '0;
            o_syncreq_s <= '0;
            o_atdata_m  <= '0;
            o_atid_m    <= '0;
            o_atbytes_m <= '0;
            o_atvalid_m <= 1'b0;
            o_afready_m <= 1'b0;
        end else if (itmode_r) begin
            o_atready_s <= {NPORTS{fh_r[0]}} & port_en;
            o_afvalid_s <= {NPORTS{fh_r[1]}} & port_en;
            o_syncreq_s <= sync_vec;
            o_atdata_m  <= dt_drive;
            o_atid_m    <= id_r;
            o_atbytes_m <= vb_bytes_r;
            o_atvalid_m <= vb_ctl_r[0];
            o_afready_m <= vb_ctl_r[1];
        end else begin
            o_atready_s <= i_fn_atready_s;
            o_afvalid_s <= i_fn_afvalid_s;
            o_syncreq_s <= i_fn_syncreq_s | sync_vec;
            o_atdata_m  <= i_fn_atdata_m;
            o_atid_m    <= i_fn_atid_m;
            o_atbytes_m <= i_fn_atbytes_m;
            o_atvalid_m <= i_fn_atvalid_m;
            o_afready_m <= i_fn_afready_m;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_funnel_ctrl <= TFIT_FC_RESET;
            o_itmode      <= 1'b0;
        end else begin
            o_funnel_ctrl <= fc_r;
            o_itmode      <= itmode_r;
        end
    end
endmodule

// ---- tfit_regs_asserts.sv ----
// Purpose: Assertions on the ports of tfit_regs
// Assumes: Zero-wait APB, full write strobes, one slave port enabled
// Notes:   ID and data output checks are skipped when integration mode is off
`timescale 1ns/1ps
module tfit_regs_asserts
    import tfit_pkg::*;
#(
    parameter int NPORTS = TFIT_NPORTS
) (
    // Clock, reset and APB
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [11:0]            i_paddr,
    input  wire logic [31:0]            i_pwdata,
    input  wire logic [3:0]             i_pstrb,
    input  wire logic [31:0]            o_prdata,
    input  wire logic                   o_pready,
    // Trace lines
    input  wire logic                   i_atready_m,
    input  wire logic                   i_afvalid_m,
    input  wire logic                   i_syncreq_m,
    input  wire logic [NPORTS-1:0]      o_syncreq_s,
    input  wire logic [TFIT_DATA_W-1:0] o_atdata_m,
    input  wire logic [TFIT_ID_W-1:0]   o_atid_m,
    input  wire logic [TFIT_FC_W-1:0]   o_funnel_ctrl,
    input  wire logic                   o_itmode
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire logic setup_w = i_psel && !i_penable;
    wire logic wr_w    = setup_w && i_pwrite && i_pstrb == 4'hf;
    wire logic rd_w    = setup_w && !i_pwrite;
    wire logic rd_sync = rd_w && i_paddr == TFIT_OFS_SYNC_TEST;
    wire logic wr_sync = wr_w && i_paddr == TFIT_OFS_SYNC_TEST && i_pwdata[0];

    a_pready_after_setup: assert property (setup_w |=> o_pready)
        else $error("no ready after setup");
    a_prdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    a_sync_pulse_out: assert property (wr_sync |-> ##2 ((o_syncreq_s & o_funnel_ctrl[NPORTS-1:0])
        == o_funnel_ctrl[NPORTS-1:0])) else $error("sync pulse missing");
    a_sync_latch_set: assert property (i_syncreq_m ##1 rd_sync |=> o_prdata[0])
        else $error("sync latch lost a pulse");
    a_sync_read_clear: assert property (rd_sync && !i_syncreq_m ##1 (!i_syncreq_m) [*2]
        ##1 rd_sync |=> !o_prdata[0]) else $error("sync latch not cleared");
    a_flush_read_in: assert property (rd_w && i_paddr == TFIT_OFS_FLUSH_TEST |=>
        o_prdata[1:0] == {$past(i_afvalid_m), $past(i_atready_m)}) else $error("flush read");
    a_id_drive_out: assert property (wr_w && i_paddr == TFIT_OFS_ID_TEST && o_itmode |->
        ##2 (!o_itmode || o_atid_m == $past(i_pwdata[6:0], 2))) else $error("id drive");
    a_data_drive_ends: assert property (wr_w && i_paddr == TFIT_OFS_DATA_TEST && o_itmode |->
        ##2 (!o_itmode || {o_atdata_m[127], o_atdata_m[0]} == {$past(i_pwdata[16], 2),
        $past(i_pwdata[0], 2)})) else $error("data drive");

    c_sync_write: cover property (wr_sync);
    c_sync_seen: cover property (i_syncreq_m ##1 rd_sync);
    c_normal_write: cover property (wr_w && !o_itmode);
endmodule

bind tfit_regs tfit_regs_asserts #(.NPORTS(NPORTS)) i_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .i_atready_m(i_atready_m),
    .i_afvalid_m(i_afvalid_m), .i_syncreq_m(i_syncreq_m), .o_syncreq_s(o_syncreq_s),
    .o_atdata_m(o_atdata_m), .o_atid_m(o_atid_m), .o_funnel_ctrl(o_funnel_ctrl),
    .o_itmode(o_itmode));

// ---- tfit_partner.sv ----
// Purpose: Trace sources and sink around the funnel test registers
// Assumes: Bench picks the port under test and the line levels
// Notes:   Other ports show the inverse so a wrong port select is seen
`timescale 1ns/1ps
module tfit_partner
    import tfit_pkg::*;
(
    // Bench control
    input  wire logic [2:0]              i_port,
    input  wire logic [127:0]            i_val,
    input  wire logic [3:0]              i_ctl,
    input  wire logic                    i_sync,
    // Source lines
    output logic      [8*TFIT_DATA_W-1:0] o_atdata_s,
    output logic      [8*TFIT_ID_W-1:0]   o_atid_s,
    output logic      [8*TFIT_BYTES_W-1:0] o_atbytes_s,
    output logic      [7:0]              o_atvalid_s,
    output logic      [7:0]              o_afready_s,
    // Sink lines
    output logic                         o_atready_m,
    output logic                         o_afvalid_m,
    output logic                         o_syncreq_m
);
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            o_atdata_s[p*128 +: 128] = (3'(p) == i_port) ? i_val : ~i_val;
            o_atid_s[p*7 +: 7]       = (3'(p) == i_port) ? i_val[6:0] : ~i_val[6:0];
            o_atbytes_s[p*2 +: 2]    = (3'(p) == i_port) ? i_val[9:8] : ~i_val[9:8];
            o_atvalid_s[p]           = i_ctl[0] ^ (3'(p) != i_port);
            o_afready_s[p]           = i_ctl[1] ^ (3'(p) != i_port);
        end
    end
    assign o_atready_m = i_ctl[2];
    assign o_afvalid_m = i_ctl[3];
    assign o_syncreq_m = i_sync;
endmodule

// ---- tfit_regs_test.sv ----
// Purpose: Self-checking bench for tfit_regs
// Assumes: One idle cycle between APB transfers
// Notes:   Integration rows enable one slave port at a time
`timescale 1ns/1ps
module tfit_regs_test
    import tfit_pkg::*;
;
    typedef struct packed { logic [11:0] a; logic [31:0] d; } tfit_row_t;
    logic          clk, rst, psel, penable, pwrite, syncp, pready, pslverr, itmode, err;
    logic          atvalid_m, afready_m, atready_m, afvalid_m, syncreq_m;
    logic [1:0]    atbytes_m;
    logic [2:0]    port;
    logic [3:0]    pstrb, ctl;
    logic [6:0]    atid_m;
    logic [7:0]    fn_s, atvalid_s, afready_s, atready_s, afvalid_s, syncreq_s;
    logic [11:0]   paddr;
    logic [12:0]   fctl;
    logic [15:0]   atbytes_s;
    logic [31:0]   pwdata, prdata, rd;
    logic [55:0]   atid_s;
    logic [127:0]  val, fn_m, atdata_m;
    logic [1023:0] atdata_s;
    int            n_mismatch = 0;
    int            n_checks = 0;
    int            hits;
    tfit_row_t     rows [8] = '{'{12'heec, 32'h1a5c3}, '{12'heec, 32'h05a3c}, '{12'hef4, 32'h2},
        '{12'hef4, 32'h1}, '{12'hef8, 32'h55}, '{12'hef8, 32'h2a}, '{12'hefc, 32'h201},
        '{12'hefc, 32'h102}};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    tfit_regs i_dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_atdata_s(atdata_s),
        .i_atid_s(atid_s), .i_atbytes_s(atbytes_s), .i_atvalid_s(atvalid_s),
        .i_afready_s(afready_s), .o_atready_s(atready_s), .o_afvalid_s(afvalid_s),
        .o_syncreq_s(syncreq_s), .i_atready_m(atready_m), .i_afvalid_m(afvalid_m),
        .i_syncreq_m(syncreq_m), .o_atdata_m(atdata_m), .o_atid_m(atid_m),
        .o_atbytes_m(atbytes_m), .o_atvalid_m(atvalid_m), .o_afready_m(afready_m),
        .i_fn_atready_s(fn_s), .i_fn_afvalid_s(fn_s), .i_fn_syncreq_s(fn_s),
        .i_fn_atdata_m(fn_m), .i_fn_atid_m(fn_m[6:0]), .i_fn_atbytes_m(fn_m[9:8]),
        .i_fn_atvalid_m(fn_m[10]), .i_fn_afready_m(fn_m[11]), .o_funnel_ctrl(fctl),
        .o_itmode(itmode));
    tfit_partner i_far (.i_port(port), .i_val(val), .i_ctl(ctl), .i_sync(syncp),
        .o_atdata_s(atdata_s), .o_atid_s(atid_s), .o_atbytes_s(atbytes_s),
        .o_atvalid_s(atvalid_s), .o_afready_s(afready_s), .o_atready_m(atready_m),
        .o_afvalid_m(afvalid_m), .o_syncreq_m(syncreq_m));

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The idle cycle first keeps every strobe change one edge apart
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk) #1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 1'b0, wr, a, d, 4'hf};
        @(posedge clk) #1;
        penable = 1'b1;
        for (n = 0; n < 4 && pready !== 1'b1; n++) @(posedge clk) #1;
        if (n == 4) begin
            n_mismatch++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        @(posedge clk) #1;
        {psel, penable} = 2'b00;
    endtask

    // Register-layout view of a data word, id/bytes field and four control lines
    function automatic logic [31:0] pick(input logic [11:0] a, input logic [127:0] d,
                                         input logic [9:0] f, input logic [3:0] c);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            12'heec: begin
                for (int k = 1; k < 16; k++) v[k] = d[8*k-1];
                v[16] = d[127];
                v[0] = d[0];
            end
            12'hef4: v[1:0] = c[3:2];
            12'hef8: v[6:0] = f[6:0];
            default: v[9:0] = {f[9:8], 6'h0, c[1:0]};
        endcase
        return v;
    endfunction

    initial begin
        {rst, psel, penable, pwrite, syncp, paddr, pwdata, pstrb} = {5'h10, 48'h0};
        {port, ctl, fn_s, val} = '0;
        fn_m = {4{32'hc3a50f1e}};
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        apb(1, TFIT_OFS_ITMODE, 32'hffffffff);
        apb(0, TFIT_OFS_ITMODE, 32'h0);
        check("mode bit", 32'h1, rd);
        check("mode out", 32'h1, 32'(itmode));
        for (int i = 0; i < 8; i++) begin
            port = 3'(i);
            val = {rows[i].d * 32'h2f, ~rows[i].d, rows[i].d ^ 32'h0f0f00ff, rows[i].d << 5};
            ctl = rows[i].d[3:0] ^ 4'(i);
            apb(1, TFIT_OFS_FUNNEL_CTRL, 32'h300 | (32'h1 << i));
            apb(1, rows[i].a, rows[i].d);
            check("drive", rows[i].d, pick(rows[i].a, atdata_m, {atbytes_m, 1'b0, atid_m},
                {afvalid_s[port], atready_s[port], afready_m, atvalid_m}));
            apb(0, rows[i].a, 32'h0);
            check("observe", pick(rows[i].a, val, val[9:0], ctl), rd);
            $display("row %0d done", i);
        end
        syncp = 1'b1;
        @(posedge clk) #1;
        syncp = 1'b0;
        apb(0, TFIT_OFS_SYNC_TEST, 32'h0);
        check("sync latch", 32'h1, rd);
        apb(0, TFIT_OFS_SYNC_TEST, 32'h0);
        check("sync clear", 32'h0, rd);
        // A pulse still high at the clearing read's setup edge must survive it
        syncp = 1'b1;
        fork
            apb(0, TFIT_OFS_SYNC_TEST, 32'h0);
            begin
                repeat (2) @(posedge clk);
                #1 syncp = 1'b0;
            end
        join
        check("sync during read", 32'h1, rd);
        apb(0, TFIT_OFS_SYNC_TEST, 32'h0);
        check("sync kept", 32'h1, rd);
        apb(0, TFIT_OFS_SYNC_TEST, 32'h0);
        check("sync cleared", 32'h0, rd);
        for (int v = 0; v < 2; v++) begin
            apb(1, TFIT_OFS_SYNC_TEST, 32'(1 - v));
            hits = 0;
            repeat (6) begin
                hits += int'(syncreq_s === 8'h80);
                @(posedge clk) #1;
            end
            check("sync pulses", 32'(1 - v), 32'(hits));
        end
        $display("sync test done");
        fn_s = 8'h5a;
        apb(1, TFIT_OFS_ITMODE, 32'h0);
        apb(1, TFIT_OFS_ID_TEST, 32'h33);
        check("normal id", 32'(fn_m[6:0]), 32'(atid_m));
        check("normal ready", 32'h5a, 32'(atready_s));
        apb(0, 12'h004, 32'h0);
        check("unmapped", 32'h0, rd);
        check("unmapped error", 32'h0, 32'(err));
        $display("normal mode test done");
        // Mode set again so that the reset below has something to clear
        apb(1, TFIT_OFS_ITMODE, 32'h1);
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        apb(0, TFIT_OFS_FUNNEL_CTRL, 32'h0);
        check("control reset", 32'h300, rd);
        apb(0, TFIT_OFS_ITMODE, 32'h0);
        check("mode reset", 32'h0, rd);
        check("mode out reset", 32'h0, 32'(itmode));
        check("control out", 32'h300, 32'(fctl));
        $display("reset test done");
        test_done();
    end
endmodule
